// >>> testbench/tws_host_model.sv
// two-wire host master driving the serial clock and pulling data low
`timescale 1ns/1ns
`default_nettype none
module tws_host_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  localparam int QTR = 12;
  // idle bus: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // third of a bit slot, stepped on falling core edges
  task automatic qwait();
    repeat (QTR) @(negedge clock);
  endtask : qwait
  // start or repeated start
  task automatic start();
    sda_low = 1'b0;
    qwait();
    scl = 1'b1;
    qwait();
    sda_low = 1'b1;
    qwait();
    scl = 1'b0;
    qwait();
  endtask : start
  // stop ends every frame
  task automatic stop();
    sda_low = 1'b1;
    qwait();
    scl = 1'b1;
    qwait();
    sda_low = 1'b0;
    qwait();
  endtask : stop
  // data set with clock low, sampled at end of clock high
  task automatic bit_slot(input logic b, output logic r);
    sda_low = ~b;
    qwait();
    scl = 1'b1;
    qwait();
    r = sda;
    scl = 1'b0;
    qwait();
  endtask : bit_slot
  // byte out msb first, returns acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], r);
    end
    bit_slot(1'b1, r);
    ack = ~r;
  endtask : send
  // byte in, then ack low or final no-ack
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, r);
      b[i] = r;
    end
    bit_slot(last, r);
  endtask : recv
endmodule : tws_host_model
`default_nettype wire

// >>> testbench/tws_reg_slave_props.sv
// pin-level checks of the two-wire register slave
`timescale 1ns/1ns
`default_nettype none
module tws_reg_slave_props #(
  parameter int REG_COUNT = 256
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic slave_address_select,
  input wire logic [tws_pkg::IDX_W-1:0] core_rd_index,
  input wire logic [tws_pkg::REG_W-1:0] core_rd_data,
  input wire logic core_wr_pulse,
  input wire logic [tws_pkg::IDX_W-1:0] core_wr_index,
  input wire logic [tws_pkg::REG_W-1:0] core_wr_data
);
  import tws_pkg::*;
  // link side: open-drain pull-down and its timing against the serial clock
  a_drive_only_low: assert property (
    @(posedge link_clk) disable iff (!rst_b) sda_out == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_low: assert property (
    @(posedge link_clk) disable iff (!rst_b) $past(rst_b, 4) && $changed(sda_oe) |-> !scl_in)
    else $error("data drive changed with serial clock high");
  a_oe_sync_delay: assert property (
    @(posedge link_clk) disable iff (!rst_b) $fell(scl_in) |=> $stable(sda_oe))
    else $error("data drive reacted before synchronisation");
  a_oe_release_bound: assert property (
    @(posedge link_clk) disable iff (!rst_b) $rose(sda_oe) |-> ##[1:400] !sda_oe)
    else $error("data line never released");
  a_oe_reset_clear: assert property (
    @(posedge link_clk) !rst_b [*2] |-> ##2 !sda_oe)
    else $error("data drive kept through reset");
  // core side: commit pulses
  a_pulse_spacing: assert property (
    @(posedge clock) disable iff (!rst_b) core_wr_pulse |=> !core_wr_pulse [*8])
    else $error("commits closer than a byte");
  a_core_reset_zero: assert property (
    @(posedge clock) !rst_b |=> !core_wr_pulse && core_wr_data == '0 && core_wr_index == '0)
    else $error("commit outputs not cleared by reset");
  a_quiet_after_reset: assert property (
    @(posedge clock) $rose(rst_b) |-> !core_wr_pulse [*8])
    else $error("commit without a serial frame");
endmodule : tws_reg_slave_props
bind tws_reg_slave tws_reg_slave_props #(.REG_COUNT(REG_COUNT)) u_props (.clock(clock),
  .rst_b(rst_b), .clk_en(clk_en), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .slave_address_select(slave_address_select),
  .core_rd_index(core_rd_index), .core_rd_data(core_rd_data),
  .core_wr_pulse(core_wr_pulse), .core_wr_index(core_wr_index),
  .core_wr_data(core_wr_data));
`default_nettype wire

// >>> testbench/tws_reg_slave_test.sv
// self-checking bench of the two-wire register slave
`timescale 1ns/1ns
`default_nettype none
module tws_reg_slave_test;
  import tws_pkg::*;
  logic clock, link_clk, rst_b, clk_en, sel, sda_oe, sda_out, wr_pulse;
  logic scl, host_low;
  logic [7:0] rd_idx, wr_index;
  logic [15:0] rd_data, wr_data;
  wire logic sda;
  logic [7:0] last_wi;
  logic [15:0] last_wd;
  int err_count = 0;
  int n_checks = 0;
  // open-drain wire with pull-up
  assign sda = ~((sda_oe & ~sda_out) | host_low);
  // clocks: core 40 ns, link 48 ns offset
  always #20 clock = ~clock;
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  tws_reg_slave #(.REG_COUNT(256)) DUT (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
    .link_clk(link_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .slave_address_select(sel), .core_rd_index(rd_idx), .core_rd_data(rd_data),
    .core_wr_pulse(wr_pulse), .core_wr_index(wr_index), .core_wr_data(wr_data));
  tws_host_model host (.clock(clock), .sda(sda), .scl(scl), .sda_low(host_low));
  // last committed word seen on the core side, sampled off the launch edge
  always @(negedge clock) begin
    if (wr_pulse === 1'b1) begin
      last_wi <= wr_index;
      last_wd <= wr_data;
    end
  end
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // write frame: address, index, n data bytes
  task automatic wr(input logic [7:0] adr, input logic [7:0] idx, input logic [31:0] d,
                    input int n, input logic ok);
    logic a;
    host.start();
    host.send(adr, a);
    check({15'h0000, a}, {15'h0000, ok});
    if (ok) begin
      host.send(idx, a);
      check({15'h0000, a}, 16'h0001);
      for (int i = n - 1; i >= 0; i--) begin
        host.send(d[8*i +: 8], a);
        check({15'h0000, a}, 16'h0001);
      end
    end
    host.stop();
  endtask : wr
  // read frame: index, repeated start, n bytes, final no-ack
  task automatic rd(input logic [7:0] idx, input int n, input logic [31:0] exp);
    logic a;
    logic [7:0] b;
    host.start();
    host.send(SLAVE_ADDR_LO, a);
    host.send(idx, a);
    host.start();
    host.send(SLAVE_ADDR_LO | 8'h01, a);
    check({15'h0000, a}, 16'h0001);
    for (int i = n - 1; i >= 0; i--) begin
      host.recv(i == 0, b);
      check({8'h00, b}, {8'h00, exp[8*i +: 8]});
    end
    check({15'h0000, sda_oe}, 16'h0000);
    host.stop();
  endtask : rd
  // core-side look at one register
  task automatic peek(input logic [7:0] idx, input logic [15:0] exp);
    rd_idx = idx;
    repeat (3) @(negedge clock);
    check(rd_data, exp);
  endtask : peek
  // hang guard
  initial begin
    repeat (90000) @(posedge clock);
    err_count++;
    $display("MISMATCH at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    stop_test();
  end
  // main sequence
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    sel = 1'b0;
    rd_idx = 8'h00;
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    repeat (8) @(negedge clock);
    peek(8'h09, REG_RESET);
    $display("test reset done");
    wr(SLAVE_ADDR_LO, 8'h09, 32'h0284_1234, 4, 1'b1);
    peek(8'h09, 16'h0284);
    peek(8'h0a, 16'h1234);
    check({8'h00, last_wi}, 16'h000a);
    check(last_wd, 16'h1234);
    $display("test word write done");
    rd(8'h09, 4, 32'h0284_1234);
    $display("test word read done");
    wr(SLAVE_ADDR_LO, 8'h0b, 32'h0000_00ab, 1, 1'b1);
    peek(8'h0b, REG_RESET);
    check(last_wd, 16'h1234);
    wr(SLAVE_ADDR_LO, LOW_BYTE_IDX, 32'h0000_00cd, 1, 1'b1);
    peek(8'h0b, 16'habcd);
    check({8'h00, last_wi}, 16'h000b);
    check(last_wd, 16'habcd);
    $display("test bytewise write done");
    rd(8'h0b, 1, 32'h0000_00ab);
    rd(LOW_BYTE_IDX, 1, 32'h0000_00cd);
    $display("test bytewise read done");
    wr(SLAVE_ADDR_HI, 8'h20, 32'h0000_5a5a, 2, 1'b0);
    sel = 1'b1;
    repeat (4) @(negedge clock);
    wr(SLAVE_ADDR_LO, 8'h20, 32'h0000_5a5a, 2, 1'b0);
    wr(SLAVE_ADDR_HI, 8'h20, 32'h0000_beef, 2, 1'b1);
    peek(8'h20, 16'hbeef);
    check({8'h00, last_wi}, 16'h0020);
    check(last_wd, 16'hbeef);
    $display("test address select done");
    // clock enable low freezes the core read port
    rd_idx = 8'h09;
    clk_en = 1'b0;
    repeat (4) @(negedge clock);
    check(rd_data, 16'hbeef);
    clk_en = 1'b1;
    peek(8'h09, 16'h0284);
    $display("test clock enable done");
    stop_test();
  end
endmodule : tws_reg_slave_test
`default_nettype wire

// >>> verilog/tws_cmd_if.sv
// command carrier between serial engine and register file
`timescale 1ns/1ns
`default_nettype none
interface tws_cmd_if;
  import tws_pkg::*;
  logic valid;
  tws_op_t op;
  logic [IDX_W-1:0] idx;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] rdata;
  modport producer (output valid, output op, output idx, output wdata, input rdata);
  modport consumer (input valid, input op, input idx, input wdata, output rdata);
endinterface : tws_cmd_if
`default_nettype wire

// >>> verilog/tws_pkg.sv
// shared constants and types for the two-wire register access slave
package tws_pkg;
  // register file geometry
  localparam int REG_W = 16;
  localparam int IDX_W = 8;
  localparam int BYTE_W = 8;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  // index of the low-byte access register
  localparam logic [IDX_W-1:0] LOW_BYTE_IDX = 8'h7f;
  // slave addresses chosen by the select pin (write form, bit 0 clear)
  localparam logic [7:0] SLAVE_ADDR_LO = 8'h90;
  localparam logic [7:0] SLAVE_ADDR_HI = 8'hb8;
  // direction bit position in the address byte, 1 means read
  localparam int DIR_BIT = 0;
  // serial bits per byte before the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  // commands passed from the serial engine to the register file
  typedef enum logic [1:0] {
    OP_READ,
    OP_WORD,
    OP_UPPER,
    OP_LOW
  } tws_op_t;
endpackage : tws_pkg

// >>> verilog/tws_reg_slave.sv
// two-wire serial slave giving access to the 16-bit register file
//
// Overview of operation
// RULE1: after start and matching write address, ack, take index then two data bytes
// RULE2: acknowledge every received byte of a write, index and data alike
// RULE3: commit a written word only after both bytes have arrived
// RULE4: after each complete written word, advance the register index
// RULE5: host ends a write with a repeated start or a stop
// RULE6: host reads by writing index, repeated start, then read address
// RULE7: host clocks read data bytewise and acknowledges each byte low except the last
// RULE8: after each 16 bits sent, advance the register index
// RULE9: host no-acknowledge ends a read; device releases the data line
// RULE10: every register is accessed as a 16-bit quantity
// RULE11: bytewise write: upper byte to target, lower byte to low-byte register
// RULE12: a lone upper-byte write never changes the stored register value
// RULE13: bytewise read: target gives upper byte, low-byte register gives lower
// RULE14: host answers each single-byte read with a no-acknowledge
// RULE15: bus transitions are spaced by a minimum of sampling clock cycles
// RULE16: device only drives data low, high is left to the pull-up
// RULE17: host signals final no-acknowledge by leaving data floating high
// RULE18: respond to address 0x90 with select pin low, 0xb8 with it high
// RULE19: address bit zero selects direction: zero write, one read
// RULE20: start is data falling with clock high, stop is data rising
// RULE21: serial lines are synchronised before edge and condition detection
// RULE22: a read after repeated start returns the most recently written index
`timescale 1ns/1ns
`default_nettype none
module tws_reg_slave #(
  parameter int REG_COUNT = 256
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic slave_address_select,
  input wire logic [tws_pkg::IDX_W-1:0] core_rd_index,
  output logic [tws_pkg::REG_W-1:0] core_rd_data,
  output logic core_wr_pulse,
  output logic [tws_pkg::IDX_W-1:0] core_wr_index,
  output logic [tws_pkg::REG_W-1:0] core_wr_data
);
  import tws_pkg::*;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_INDEX,
    ST_INDEX_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } tws_state_t;

  // ---------------- link domain ----------------
  logic [1:0] lrst_sync_reg;
  logic [1:0] len_sync_reg;
  logic link_rst_b;
  logic link_en;
  logic scl_s1_reg, scl_s2_reg, scl_q_reg;
  logic sda_s1_reg, sda_s2_reg, sda_q_reg;
  logic sel_s1_reg, sel_s2_reg;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [7:0] own_addr;
  logic addr_match;
  logic [7:0] sr_shifted;
  logic [REG_W-1:0] rd_word;
  logic [IDX_W-1:0] index_inc;
  logic upper_pending;

  tws_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sr_reg, sr_next;
  logic [7:0] tx_reg, tx_next;
  logic [IDX_W-1:0] index_reg, index_next;
  logic byte_sel_reg, byte_sel_next;
  logic [7:0] hi_reg, hi_next;
  logic dir_reg, dir_next;
  logic oe_reg, oe_next;
  logic cmd_valid_reg, cmd_valid_next;
  tws_op_t cmd_op_reg, cmd_op_next;
  logic [IDX_W-1:0] cmd_idx_reg, cmd_idx_next;
  logic [REG_W-1:0] cmd_wdata_reg, cmd_wdata_next;

  tws_cmd_if link_cmd ();
  tws_cmd_if core_cmd ();

  // reset and clock enable brought into the link domain
  always_ff @(posedge link_clk) begin
    lrst_sync_reg <= {lrst_sync_reg[0], rst_b};
    len_sync_reg <= {len_sync_reg[0], clk_en};
  end
  assign link_rst_b = lrst_sync_reg[1];
  assign link_en = len_sync_reg[1];

  // pin synchronisers, third stage only for edge history
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      scl_s1_reg <= 1'h1;
      scl_s2_reg <= 1'h1;
      scl_q_reg <= 1'h1;
      sda_s1_reg <= 1'h1;
      sda_s2_reg <= 1'h1;
      sda_q_reg <= 1'h1;
      sel_s1_reg <= 1'h0;
      sel_s2_reg <= 1'h0;
    end else if (link_en) begin
      scl_s1_reg <= scl_in; // RULE21
      scl_s2_reg <= scl_s1_reg;
      scl_q_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in; // RULE21
      sda_s2_reg <= sda_s1_reg;
      sda_q_reg <= sda_s2_reg;
      sel_s1_reg <= slave_address_select;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  // edge and bus condition decode on synchronised samples
  assign scl_rise = scl_s2_reg & ~scl_q_reg; // RULE15
  assign scl_fall = ~scl_s2_reg & scl_q_reg; // RULE15
  assign start_det = scl_s2_reg & scl_q_reg & sda_q_reg & ~sda_s2_reg; // RULE20
  assign stop_det = scl_s2_reg & scl_q_reg & ~sda_q_reg & sda_s2_reg; // RULE20

  // address match and helpers
  assign own_addr = sel_s2_reg ? SLAVE_ADDR_HI : SLAVE_ADDR_LO; // RULE18
  assign addr_match = (sr_reg[7:1] == own_addr[7:1]);
  assign sr_shifted = {sr_reg[6:0], sda_s2_reg};
  assign rd_word = link_cmd.rdata;
  assign index_inc = index_reg + 8'h01;
  assign upper_pending = (state_reg == ST_WDATA) && byte_sel_reg
                         && (index_reg != LOW_BYTE_IDX);

  // serial engine next-state logic
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sr_next = sr_reg;
    tx_next = tx_reg;
    index_next = index_reg;
    byte_sel_next = byte_sel_reg;
    hi_next = hi_reg;
    dir_next = dir_reg;
    oe_next = oe_reg;
    cmd_valid_next = 1'h0;
    cmd_op_next = cmd_op_reg;
    cmd_idx_next = cmd_idx_reg;
    cmd_wdata_next = cmd_wdata_reg;
    if (start_det || stop_det) begin
      // lone upper byte is only staged, never written
      if (upper_pending) begin
        cmd_valid_next = 1'h1; // RULE12
        cmd_op_next = OP_UPPER; // RULE11
        cmd_idx_next = index_reg;
        cmd_wdata_next = {BYTE_ZERO, hi_reg};
      end
      state_next = start_det ? ST_ADDR : ST_IDLE; // RULE5
      cnt_next = 4'h0;
      byte_sel_next = 1'h0;
      oe_next = 1'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (scl_rise && cnt_reg != BYTE_BITS) begin
            sr_next = sr_shifted;
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == BYTE_BITS) begin
            cnt_next = 4'h0;
            if (addr_match) begin
              oe_next = 1'h1; // RULE1
              dir_next = sr_reg[DIR_BIT]; // RULE19
              state_next = ST_ADDR_ACK;
              if (sr_reg[DIR_BIT]) begin
                cmd_valid_next = 1'h1; // RULE22
                cmd_op_next = OP_READ;
                cmd_idx_next = index_reg;
              end
            end else begin
              state_next = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (dir_reg) begin
              state_next = ST_RDATA;
              tx_next = rd_word[15:8];
              oe_next = ~rd_word[15]; // RULE16
              byte_sel_next = 1'h0;
            end else begin
              state_next = ST_INDEX;
              oe_next = 1'h0;
            end
          end
        end
        ST_INDEX: begin
          if (scl_rise && cnt_reg != BYTE_BITS) begin
            sr_next = sr_shifted;
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == BYTE_BITS) begin
            cnt_next = 4'h0;
            index_next = sr_reg; // RULE1
            byte_sel_next = 1'h0;
            oe_next = 1'h1; // RULE2
            state_next = ST_INDEX_ACK;
          end
        end
        ST_INDEX_ACK: begin
          if (scl_fall) begin
            oe_next = 1'h0;
            state_next = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (scl_rise && cnt_reg != BYTE_BITS) begin
            sr_next = sr_shifted;
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == BYTE_BITS) begin
            cnt_next = 4'h0;
            oe_next = 1'h1; // RULE2
            state_next = ST_WDATA_ACK;
            if (index_reg == LOW_BYTE_IDX) begin
              cmd_valid_next = 1'h1; // RULE11
              cmd_op_next = OP_LOW;
              cmd_idx_next = index_reg;
              cmd_wdata_next = {BYTE_ZERO, sr_reg};
            end else if (!byte_sel_reg) begin
              hi_next = sr_reg; // RULE3
              byte_sel_next = 1'h1;
            end else begin
              cmd_valid_next = 1'h1; // RULE3
              cmd_op_next = OP_WORD;
              cmd_idx_next = index_reg;
              cmd_wdata_next = {hi_reg, sr_reg}; // RULE1
              index_next = index_inc; // RULE4
              byte_sel_next = 1'h0;
            end
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            oe_next = 1'h0;
            state_next = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise && cnt_reg != BYTE_BITS) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == BYTE_BITS) begin
            cnt_next = 4'h0;
            oe_next = 1'h0;
            state_next = ST_RACK;
            if (byte_sel_reg) begin
              index_next = index_inc; // RULE8
              cmd_valid_next = 1'h1;
              cmd_op_next = OP_READ;
              cmd_idx_next = index_inc;
            end
          end else if (scl_fall) begin
            tx_next = {tx_reg[6:0], 1'h0};
            oe_next = ~tx_reg[6]; // RULE16
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s2_reg) begin
            state_next = ST_IGNORE; // RULE9
          end else if (scl_fall) begin
            state_next = ST_RDATA;
            if (!byte_sel_reg) begin
              tx_next = rd_word[7:0];
              oe_next = ~rd_word[7];
              byte_sel_next = 1'h1;
            end else begin
              tx_next = rd_word[15:8];
              oe_next = ~rd_word[15];
              byte_sel_next = 1'h0;
            end
          end
        end
        ST_IGNORE: begin
          oe_next = 1'h0; // RULE9
        end
        default: begin
          state_next = ST_IDLE;
          oe_next = 1'h0;
        end
      endcase
    end
  end

  // serial engine state registers
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      sr_reg <= 8'h00;
      tx_reg <= 8'h00;
      index_reg <= '0;
      byte_sel_reg <= 1'h0;
      hi_reg <= 8'h00;
      dir_reg <= 1'h0;
      oe_reg <= 1'h0;
    end else if (link_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sr_reg <= sr_next;
      tx_reg <= tx_next;
      index_reg <= index_next;
      byte_sel_reg <= byte_sel_next;
      hi_reg <= hi_next;
      dir_reg <= dir_next;
      oe_reg <= oe_next;
    end
  end

  // command registers toward the crossing
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      cmd_valid_reg <= 1'h0;
      cmd_op_reg <= OP_READ;
      cmd_idx_reg <= '0;
      cmd_wdata_reg <= '0;
    end else if (link_en) begin
      cmd_valid_reg <= cmd_valid_next;
      cmd_op_reg <= cmd_op_next;
      cmd_idx_reg <= cmd_idx_next;
      cmd_wdata_reg <= cmd_wdata_next;
    end
  end

  // open-drain data pin: output level fixed low
  assign sda_out = 1'h0; // RULE16
  assign sda_oe = oe_reg;

  assign link_cmd.valid = cmd_valid_reg;
  assign link_cmd.op = cmd_op_reg;
  assign link_cmd.idx = cmd_idx_reg;
  assign link_cmd.wdata = cmd_wdata_reg;

  tws_xfer u_xfer (
    .link_clk(link_clk),
    .link_rst_b(link_rst_b),
    .link_en(link_en),
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .lnk(link_cmd),
    .core(core_cmd)
  );

  // ---------------- core domain ----------------
  logic [REG_W-1:0] regs [REG_COUNT];
  logic [IDX_W-1:0] low_target_reg;
  logic [BYTE_W-1:0] pend_hi_reg;
  logic do_word, do_low, do_upper, do_read;
  logic [REG_W-1:0] low_word;
  logic [REG_W-1:0] rd_sel;

  // command decode
  assign do_word = core_cmd.valid && (core_cmd.op == OP_WORD);
  assign do_low = core_cmd.valid && (core_cmd.op == OP_LOW);
  assign do_upper = core_cmd.valid && (core_cmd.op == OP_UPPER);
  assign do_read = core_cmd.valid && (core_cmd.op == OP_READ);
  assign low_word = {pend_hi_reg, core_cmd.wdata[7:0]};

  // low-byte register reads back the lower byte of the last target
  assign rd_sel = (core_cmd.idx == LOW_BYTE_IDX)
                  ? {regs[low_target_reg][7:0], BYTE_ZERO} // RULE13
                  : regs[core_cmd.idx]; // RULE10
  assign core_cmd.rdata = rd_sel;

  // register file, full words only
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (clk_en) begin
      if (do_word) begin
        regs[core_cmd.idx] <= core_cmd.wdata; // RULE3
      end else if (do_low) begin
        regs[low_target_reg] <= low_word; // RULE11
        regs[LOW_BYTE_IDX] <= {BYTE_ZERO, core_cmd.wdata[7:0]};
      end
    end
  end

  // bytewise access target and staged upper byte
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      low_target_reg <= '0;
      pend_hi_reg <= 8'h00;
    end else if (clk_en) begin
      if (do_upper) begin
        low_target_reg <= core_cmd.idx; // RULE12
        pend_hi_reg <= core_cmd.wdata[7:0];
      end else if (do_read && core_cmd.idx != LOW_BYTE_IDX) begin
        low_target_reg <= core_cmd.idx; // RULE13
      end
    end
  end

  // core-side view of reads and committed writes
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      core_rd_data <= '0;
      core_wr_pulse <= 1'h0;
      core_wr_index <= '0;
      core_wr_data <= '0;
    end else if (clk_en) begin
      core_rd_data <= regs[core_rd_index];
      core_wr_pulse <= do_word || do_low;
      core_wr_index <= do_low ? low_target_reg : core_cmd.idx;
      core_wr_data <= do_low ? low_word : core_cmd.wdata;
    end
  end
endmodule : tws_reg_slave
`default_nettype wire

// >>> verilog/tws_xfer.sv
// toggle handshake carrying commands from link domain to core domain
`timescale 1ns/1ns
`default_nettype none
module tws_xfer (
  input wire logic link_clk,
  input wire logic link_rst_b,
  input wire logic link_en,
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  tws_cmd_if.consumer lnk,
  tws_cmd_if.producer core
);
  import tws_pkg::*;

  tws_op_t op_hold_reg;
  logic [IDX_W-1:0] idx_hold_reg;
  logic [REG_W-1:0] wdata_hold_reg;
  logic req_tgl_reg;
  logic ack_s1_reg, ack_s2_reg, ack_q_reg;
  logic [REG_W-1:0] rdata_reg;
  logic req_s1_reg, req_s2_reg, req_q_reg;
  logic ack_tgl_reg;
  logic [REG_W-1:0] rd_hold_reg;
  logic ack_seen;

  assign ack_seen = ack_s2_reg ^ ack_q_reg;
  assign lnk.rdata = rdata_reg;

  // link side: hold command, toggle request
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      op_hold_reg <= OP_READ;
      idx_hold_reg <= '0;
      wdata_hold_reg <= '0;
      req_tgl_reg <= 1'h0;
    end else if (link_en && lnk.valid) begin
      op_hold_reg <= lnk.op;
      idx_hold_reg <= lnk.idx;
      wdata_hold_reg <= lnk.wdata;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // link side: acknowledge sync, capture returned word
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      ack_s1_reg <= 1'h0;
      ack_s2_reg <= 1'h0;
      ack_q_reg <= 1'h0;
      rdata_reg <= '0;
    end else if (link_en) begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_q_reg <= ack_s2_reg;
      if (ack_seen) begin
        rdata_reg <= rd_hold_reg;
      end
    end
  end

  // core side: request pulse, fields stable while it crosses
  assign core.valid = req_s2_reg ^ req_q_reg;
  assign core.op = op_hold_reg;
  assign core.idx = idx_hold_reg;
  assign core.wdata = wdata_hold_reg;

  // core side: request sync, answer capture, acknowledge toggle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      req_s1_reg <= 1'h0;
      req_s2_reg <= 1'h0;
      req_q_reg <= 1'h0;
      ack_tgl_reg <= 1'h0;
      rd_hold_reg <= '0;
    end else if (clk_en) begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      req_q_reg <= req_s2_reg;
      if (core.valid) begin
        rd_hold_reg <= core.rdata;
        ack_tgl_reg <= ~ack_tgl_reg;
      end
    end
  end
endmodule : tws_xfer
`default_nettype wire
